// ===== core/lcio_top.v
// line card i/o port: pin control, input conditioning, apb registers
// Function
// RQ1: per-line direction set by host write
// RQ2: output lines hold host-written latched levels
// RQ3: first input debounced, 0..15 ms steps
// RQ4: second input up/down filtered, programmable interval
// RQ5: demux splits first line, ground key replaces second
// RQ6: demuxed bits use same two filters
// RQ7: channel read returns filtered bits, aux lines
// RQ8: bulk reads give all channels, sampled together
// RQ9: build option picks five, dual, two-line variant
// RQ10: chopper clock 256 or 292.57 kHz, 50%; driven on the dual variant only, held low otherwise
// RQ11: chopper derived synchronously from master clock
// RQ12: access only while select asserted
// RQ13: writes and reads hit enabled channels only; with none enabled, as after reset, reads return channel 3
// RQ14: select low 16 clocks, reset on release
// RQ15: interrupt on unmasked change, held until read; a status write or mask write also releases it
// RQ16: highway clock mode turns pin into demux phase
// RQ17: data line driven only while transmitting
// RQ18: filters time from internal 1 ms tick
`timescale 1ns/1ps
`include "lcio_defines.vh"

module lcio_top #(
	parameter VARIANT = `LCIO_VAR_FIVE,
	parameter TICK_CYCLES = `LCIO_TICK_NS / `LCIO_CLK_PERIOD_NS
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire [31:0] pwdata,
	output reg [31:0] prdata,
	output reg pready,
	output reg pslverr,
	input wire [19:0] line_in,
	output reg [19:0] line_out,
	output reg [19:0] line_oe,
	input wire cs_n,
	input wire serial_shift_clock,
	input wire serial_data_line_in,
	output reg serial_data_line_out,
	output reg serial_data_line_oe,
	output reg regulator_chop_clock,
	output reg demux_phase_out,
	output reg demux_phase_oe,
	output reg irq_n
);

	// lines present per channel for the chosen build
	localparam [4:0] PRESENT = (VARIANT == `LCIO_VAR_FIVE) ? 5'h1f :
		(VARIANT == `LCIO_VAR_DUAL) ? 5'h0f : 5'h03; // RQ9
	localparam [63:0] INC_A_W = (`LCIO_CHOP_A_HZ * `LCIO_ACC_SCALE) / `LCIO_CLK_HZ;
	localparam [63:0] INC_B_W = (`LCIO_CHOP_B_NUM_HZ * `LCIO_ACC_SCALE) /
		(`LCIO_CHOP_B_DEN * `LCIO_CLK_HZ);
	localparam [31:0] INC_A = INC_A_W[31:0];
	localparam [31:0] INC_B = INC_B_W[31:0];
	localparam [31:0] TICK_LAST = TICK_CYCLES - 1;

	// lowest enabled channel, or channel 3 when none is enabled, used for single-channel reads
	function [1:0] first_ch;
		input [3:0] en;
		begin
			if (en[0]) first_ch = 2'd0;
			else if (en[1]) first_ch = 2'd1;
			else if (en[2]) first_ch = 2'd2;
			else first_ch = 2'd3;
		end
	endfunction

	// 5-bit field of channel ch from a packed 20-bit vector
	function [4:0] ch_field;
		input [19:0] v;
		input [1:0] ch;
		begin
			ch_field = v[ch*5 +: 5];
		end
	endfunction

	reg [3:0] ce_q;
	reg [19:0] dir_q, outv_q;
	reg [15:0] deb_q, samp_q;
	reg [2:0] cfg_q;
	reg [7:0] ist_q, imask_q, ist_d, prev_q;
	reg [19:0] lin_s1_q, lin_s2_q;
	reg [2:0] cs_s_q, sck_s_q;
	reg [4:0] hold_cnt_q;
	reg srst_q;
	reg [31:0] tick_cnt_q;
	reg tick_q;
	reg [31:0] chop_acc_q;
	reg [3:0] hook_q, gkey_q;
	reg [31:0] rd_d;
	reg hit_d;
	wire [3:0] d1_w, d2_w;
	wire [7:0] ev_w;
	wire sel_ok, wr_go, rd_go;
	wire [1:0] rch_w;
	wire [4:0] pins_w;
	integer i, j, k;

	// ---------------------------------------------------------------
	// pin synchronisers
	// ---------------------------------------------------------------
	// the first stage of each chain feeds only the second
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			lin_s1_q <= 20'h00000;
			lin_s2_q <= 20'h00000;
			cs_s_q <= 3'h7;
			sck_s_q <= 3'h0;
		end else begin
			lin_s1_q <= line_in;
			lin_s2_q <= lin_s1_q;
			cs_s_q <= {cs_s_q[1:0], cs_n};
			sck_s_q <= {sck_s_q[1:0], serial_shift_clock};
		end
	end

	// ---------------------------------------------------------------
	// select hold detector and reset of control, filter and interrupt state
	// ---------------------------------------------------------------
	// counts shift clock rises while select low; saturates
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			hold_cnt_q <= 5'h00;
			srst_q <= 1'b0;
		end else begin
			srst_q <= 1'b0;
			if (cs_s_q[1]) begin
				hold_cnt_q <= 5'h00;
				if (!cs_s_q[2] && hold_cnt_q >= `LCIO_CS_HOLD_EDGES) begin
					srst_q <= 1'b1; // RQ14
				end
			end else if (sck_s_q[1] && !sck_s_q[2] && hold_cnt_q != `LCIO_CS_HOLD_EDGES) begin
				hold_cnt_q <= hold_cnt_q + 5'h01; // RQ14
			end
		end
	end

	// ---------------------------------------------------------------
	// 1 ms tick and chopper clock
	// ---------------------------------------------------------------
	// phase accumulator: average frequency slightly low from the truncated increment, edges jitter by one clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			tick_cnt_q <= 32'h00000000;
			tick_q <= 1'b0;
			chop_acc_q <= 32'h00000000;
			regulator_chop_clock <= 1'b0;
		end else begin
			tick_q <= (tick_cnt_q == TICK_LAST); // RQ18
			tick_cnt_q <= (tick_cnt_q == TICK_LAST) ? 32'h00000000 : tick_cnt_q + 32'h1;
			chop_acc_q <= chop_acc_q + (cfg_q[`LCIO_CFG_CHOP_SEL] ? INC_B : INC_A); // RQ11
			regulator_chop_clock <= (VARIANT == `LCIO_VAR_DUAL) & chop_acc_q[31]; // RQ10
		end
	end

	// ---------------------------------------------------------------
	// demultiplex phase and detector capture
	// ---------------------------------------------------------------
	// phase flips every tick; line level captured before each flip
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			demux_phase_out <= 1'b0;
			demux_phase_oe <= 1'b0;
			hook_q <= 4'h0;
			gkey_q <= 4'h0;
		end else begin
			demux_phase_oe <= cfg_q[`LCIO_CFG_HWY_CLK]; // RQ16
			if (tick_q) begin
				demux_phase_out <= ~demux_phase_out; // RQ16
				for (j = 0; j < `LCIO_NCH; j = j + 1) begin
					if (demux_phase_out) hook_q[j] <= lin_s2_q[j*5]; // RQ5
					else gkey_q[j] <= lin_s2_q[j*5]; // RQ5
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// filters per channel
	// ---------------------------------------------------------------
	genvar g;
	generate
		for (g = 0; g < `LCIO_NCH; g = g + 1) begin : g_ch
			lcio_filter u_filt (
				.pclk(pclk),
				.presetn(presetn),
				.srst(srst_q),
				.tick(tick_q),
				.raw1(cfg_q[`LCIO_CFG_DEMUX] ? hook_q[g] : lin_s2_q[g*5]), // RQ6
				.raw2(cfg_q[`LCIO_CFG_DEMUX] ? gkey_q[g] : lin_s2_q[g*5+1]), // RQ5
				.deb_ms(deb_q[g*4 +: 4]),
				.samp_int(samp_q[g*4 +: 4]),
				.d1_q(d1_w[g]),
				.d2_q(d2_w[g])
			);
		end
	endgenerate

	// ---------------------------------------------------------------
	// pin drivers
	// ---------------------------------------------------------------
	// serial data line never transmits here: apb carries the data
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			line_out <= 20'h00000;
			line_oe <= 20'h00000;
			serial_data_line_out <= 1'b0;
			serial_data_line_oe <= 1'b0;
		end else begin
			for (i = 0; i < `LCIO_NCH; i = i + 1) begin
				line_out[i*5 +: 5] <= outv_q[i*5 +: 5] & PRESENT; // RQ2
				line_oe[i*5 +: 5] <= dir_q[i*5 +: 5] & PRESENT; // RQ1
			end
			serial_data_line_out <= 1'b0;
			serial_data_line_oe <= 1'b0; // RQ17
		end
	end

	// ---------------------------------------------------------------
	// apb decode and read mux
	// ---------------------------------------------------------------
	assign sel_ok = psel & ~cs_s_q[1]; // RQ12
	assign wr_go = sel_ok & penable & pready & pwrite & ~pslverr;
	assign rd_go = sel_ok & penable & pready & ~pwrite;
	assign rch_w = first_ch(ce_q); // RQ13
	assign pins_w = ch_field(lin_s2_q, rch_w) & PRESENT; // aux pins of the read channel

	// read data sampled in the setup cycle, so bulk bits are simultaneous
	always @* begin
		rd_d = 32'h00000000;
		hit_d = 1'b1;
		case (paddr)
			`LCIO_CHAN_ENABLE_OFS: rd_d[3:0] = ce_q;
			`LCIO_DIRECTION_OFS: rd_d[4:0] = ch_field(dir_q, first_ch(ce_q));
			`LCIO_OUTPUT_OFS: rd_d[4:0] = ch_field(outv_q, first_ch(ce_q));
			`LCIO_CHAN_READ_OFS: rd_d[4:0] = {pins_w[4:2], d2_w[rch_w], d1_w[rch_w]}; // RQ7
			`LCIO_BULK_D1_OFS: rd_d[3:0] = d1_w; // RQ8
			`LCIO_BULK_D2_OFS: rd_d[3:0] = d2_w; // RQ8
			`LCIO_DEBOUNCE_OFS: rd_d[3:0] = deb_q[first_ch(ce_q)*4 +: 4];
			`LCIO_SAMPLE_OFS: rd_d[3:0] = samp_q[first_ch(ce_q)*4 +: 4];
			`LCIO_CONFIG_OFS: rd_d[2:0] = cfg_q;
			`LCIO_IRQ_STATUS_OFS: rd_d[7:0] = ist_q;
			`LCIO_IRQ_MASK_OFS: rd_d[7:0] = imask_q;
			default: hit_d = 1'b0;
		endcase
	end

	// no wait state: pready rises in the cycle after setup
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata <= 32'h00000000;
			pready <= 1'b0;
			pslverr <= 1'b0;
		end else begin
			pready <= sel_ok & ~penable;
			if (sel_ok & ~penable) begin
				prdata <= pwrite ? 32'h00000000 : rd_d;
				pslverr <= ~hit_d;
			end else begin
				pslverr <= 1'b0;
			end
		end
	end

	// ---------------------------------------------------------------
	// control registers
	// ---------------------------------------------------------------
	// per-channel writes land only on enabled channels
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ce_q <= `LCIO_CE_RST;
			dir_q <= `LCIO_DIR_RST;
			outv_q <= 20'h00000;
			deb_q <= 16'h0000;
			samp_q <= 16'h0000;
			cfg_q <= `LCIO_CFG_RST;
			imask_q <= 8'h00;
		end else if (srst_q) begin
			ce_q <= `LCIO_CE_RST;
			dir_q <= `LCIO_DIR_RST;
			outv_q <= 20'h00000;
			deb_q <= 16'h0000;
			samp_q <= 16'h0000;
			cfg_q <= `LCIO_CFG_RST;
			imask_q <= 8'h00;
		end else if (wr_go) begin
			case (paddr)
				`LCIO_CHAN_ENABLE_OFS: ce_q <= pwdata[3:0]; // RQ13
				`LCIO_CONFIG_OFS: cfg_q <= pwdata[2:0];
				`LCIO_IRQ_MASK_OFS: imask_q <= pwdata[7:0];
				default: ;
			endcase
			for (k = 0; k < `LCIO_NCH; k = k + 1) begin
				if (ce_q[k]) begin
					if (paddr == `LCIO_DIRECTION_OFS) dir_q[k*5 +: 5] <= pwdata[4:0]; // RQ1
					if (paddr == `LCIO_OUTPUT_OFS) outv_q[k*5 +: 5] <= pwdata[4:0]; // RQ2
					if (paddr == `LCIO_DEBOUNCE_OFS) deb_q[k*4 +: 4] <= pwdata[3:0]; // RQ3
					if (paddr == `LCIO_SAMPLE_OFS) samp_q[k*4 +: 4] <= pwdata[3:0]; // RQ4
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// interrupt status and output
	// ---------------------------------------------------------------
	assign ev_w = {d2_w, d1_w} ^ prev_q;

	// set beats clear; a read clears only the bits it returned, so none is lost
	always @* begin
		ist_d = ist_q;
		if (rd_go && paddr == `LCIO_IRQ_STATUS_OFS) ist_d = ist_d & ~prdata[7:0]; // RQ15
		if (wr_go && paddr == `LCIO_IRQ_STATUS_OFS) ist_d = ist_d & ~pwdata[7:0];
		ist_d = ist_d | ev_w; // RQ15
	end

	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ist_q <= 8'h00;
			prev_q <= 8'h00;
			irq_n <= 1'b1;
		end else if (srst_q) begin
			ist_q <= 8'h00;
			prev_q <= 8'h00;
			irq_n <= 1'b1;
		end else begin
			prev_q <= {d2_w, d1_w};
			ist_q <= ist_d;
			irq_n <= ~|(ist_q & imask_q); // RQ15
		end
	end

endmodule

// ===== core/lcio_defines.vh
// constants of the line card i/o port: register map, fields, timing
`ifndef LCIO_DEFINES_VH
`define LCIO_DEFINES_VH

// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define LCIO_CHAN_ENABLE_OFS 8'h00
`define LCIO_DIRECTION_OFS 8'h04
`define LCIO_OUTPUT_OFS 8'h08
`define LCIO_CHAN_READ_OFS 8'h0c
`define LCIO_BULK_D1_OFS 8'h10
`define LCIO_BULK_D2_OFS 8'h14
`define LCIO_DEBOUNCE_OFS 8'h18
`define LCIO_SAMPLE_OFS 8'h1c
`define LCIO_CONFIG_OFS 8'h20
`define LCIO_IRQ_STATUS_OFS 8'h24
`define LCIO_IRQ_MASK_OFS 8'h28

// ---------------------------------------------------------------
// field layout and reset values
// ---------------------------------------------------------------
`define LCIO_NCH 4
`define LCIO_NLINE 5
`define LCIO_CFG_DEMUX 0
`define LCIO_CFG_CHOP_SEL 1
`define LCIO_CFG_HWY_CLK 2
`define LCIO_CFG_RST 3'h0
`define LCIO_DIR_RST 20'h00000
`define LCIO_CE_RST 4'h0
`define LCIO_CS_HOLD_EDGES 5'h10
`define LCIO_UD_MAX 3'h7
`define LCIO_VAR_FIVE 0
`define LCIO_VAR_DUAL 1
`define LCIO_VAR_TWO 2

// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LCIO_CLK_HZ 40000000
`define LCIO_CLK_PERIOD_NS 25
`define LCIO_TICK_NS 1000000
`define LCIO_CHOP_A_HZ 256000
`define LCIO_CHOP_B_NUM_HZ 2048000
`define LCIO_CHOP_B_DEN 7
`define LCIO_ACC_SCALE 64'h0000000100000000

`endif

// ===== core/lcio_filter.v
// per-channel input conditioning: debounce and up/down counter filter
`timescale 1ns/1ps
`include "lcio_defines.vh"

module lcio_filter (
	input wire pclk,
	input wire presetn,
	input wire srst,
	input wire tick,
	input wire raw1,
	input wire raw2,
	input wire [3:0] deb_ms,
	input wire [3:0] samp_int,
	output reg d1_q,
	output reg d2_q
);

	reg [3:0] deb_cnt_q;
	reg [3:0] samp_cnt_q;
	reg [2:0] ud_q;

	// ---------------------------------------------------------------
	// debounce: new level taken after deb_ms stable ticks
	// ---------------------------------------------------------------
	// zero setting passes the input on the next clock
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			d1_q <= 1'b0;
			deb_cnt_q <= 4'h0;
		end else if (srst) begin
			d1_q <= 1'b0;
			deb_cnt_q <= 4'h0;
		end else if (raw1 == d1_q) begin
			deb_cnt_q <= 4'h0; // RQ3
		end else if (deb_cnt_q >= deb_ms) begin
			d1_q <= raw1; // RQ3
			deb_cnt_q <= 4'h0;
		end else if (tick) begin
			deb_cnt_q <= deb_cnt_q + 4'h1; // RQ18
		end
	end

	// ---------------------------------------------------------------
	// up/down counter, sampled every samp_int+1 ticks
	// ---------------------------------------------------------------
	// hysteresis: output only flips at the counter ends
	always @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			samp_cnt_q <= 4'h0;
			ud_q <= 3'h0;
			d2_q <= 1'b0;
		end else if (srst) begin
			samp_cnt_q <= 4'h0;
			ud_q <= 3'h0;
			d2_q <= 1'b0;
		end else if (tick) begin
			if (samp_cnt_q >= samp_int) begin
				samp_cnt_q <= 4'h0; // RQ4
				if (raw2 && ud_q != `LCIO_UD_MAX) begin
					ud_q <= ud_q + 3'h1;
				end else if (!raw2 && ud_q != 3'h0) begin
					ud_q <= ud_q - 3'h1;
				end
				if (raw2 && ud_q == `LCIO_UD_MAX - 3'h1) begin
					d2_q <= 1'b1; // RQ4
				end else if (!raw2 && ud_q == 3'h1) begin
					d2_q <= 1'b0; // RQ4
				end
			end else begin
				samp_cnt_q <= samp_cnt_q + 4'h1; // RQ18
			end
		end
	end

endmodule

// ===== dv/lcio_checker.sv
// port-level assertions for the line card i/o port
`timescale 1ns/1ps
// ---------------------------------------------------------------
// checker
// ---------------------------------------------------------------
module lcio_checker #(
	parameter VARIANT = 0
) (
	input wire pclk,
	input wire presetn,
	input wire psel,
	input wire penable,
	input wire pwrite,
	input wire [7:0] paddr,
	input wire pready,
	input wire pslverr,
	input wire [19:0] line_out,
	input wire [19:0] line_oe,
	input wire cs_n,
	input wire serial_data_line_oe,
	input wire regulator_chop_clock,
	input wire demux_phase_out,
	input wire irq_n
);
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	// completed transfer, and one that may release the interrupt
	wire acc = psel && penable && pready;
	wire irq_acc = acc && (paddr == 8'h24 || paddr == 8'h28);

	a_ready_access: assert property (pready |-> psel && penable)
		else $error("ready outside an access phase");
	a_ready_pulse: assert property (pready |=> !pready)
		else $error("ready held longer than one cycle");
	a_ready_latency: assert property ((!cs_n)[*4] ##0 (psel && !penable) |=> pready)
		else $error("selected setup got no answer");
	a_no_select: assert property (cs_n[*5] |-> !pready)
		else $error("answer while deselected");
	// release needs a status read or write or a mask write; the cs_n terms keep hold reset out
	a_irq_hold: assert property (!irq_n && !cs_n && $past(!cs_n, 6) && !irq_acc
		&& !$past(irq_acc) |=> !irq_n)
		else $error("interrupt dropped without status access");
	a_serial_quiet: assert property (!serial_data_line_oe)
		else $error("data line driven without transmit");
	// a write lands at the access edge and reaches the pin register one clock later
	a_out_hold: assert property ($changed(line_out) && !cs_n |-> $past(acc && pwrite, 2))
		else $error("output level moved without a write");
	a_dir_hold: assert property ($changed(line_oe) && !cs_n |-> $past(acc && pwrite, 2))
		else $error("direction moved without a write");
	a_chop_off: assert property (VARIANT != 1 |-> !regulator_chop_clock)
		else $error("chopper running on a variant without it");
	// deselected cycles are excused, though a hold reset leaves the phase and tick running
	a_phase_tick: assert property ($changed(demux_phase_out) && !cs_n
		|=> ($stable(demux_phase_out) || cs_n)[*8])
		else $error("phase toggled faster than the tick");

	c_unmapped: cover property (pslverr);
	c_irq: cover property ($fell(irq_n));
	c_drive: cover property ($rose(line_oe[0]));
endmodule

bind lcio_top lcio_checker #(.VARIANT(VARIANT)) lcio_checker_inst (.pclk, .presetn, .psel,
	.penable, .pwrite, .paddr, .pready, .pslverr, .line_out, .line_oe, .cs_n,
	.serial_data_line_oe, .regulator_chop_clock, .demux_phase_out, .irq_n);

// ===== dv/lcio_line_model.sv
// line circuit model on the pin side of the port
`timescale 1ns/1ps
// ---------------------------------------------------------------
// pin resolution
// ---------------------------------------------------------------
module lcio_line_model (
	input wire [19:0] line_out,
	input wire [19:0] line_oe,
	input wire [19:0] drv,
	input wire mux_on,
	input wire phase,
	input wire [3:0] gkey,
	output wire [19:0] line_in
);
	// multiplexed detector: ground key shows on line 0 while the phase is low
	wire [19:0] gk_w = {4'h0, gkey[3], 4'h0, gkey[2], 4'h0, gkey[1], 4'h0, gkey[0]};
	wire [19:0] det_w = (mux_on && !phase) ? ((drv & ~20'h08421) | gk_w) : drv;
	// a driven line reads back its own level, the rest show the detector
	assign line_in = (line_oe & line_out) | (~line_oe & det_w);
endmodule

// ===== dv/line_card_io_port_tb.sv
// self-checking bench for the line card i/o port
`timescale 1ns/1ps
module line_card_io_port_tb;
	reg pclk = 0;
	reg presetn = 0;
	reg psel = 0;
	reg penable = 0;
	reg pwrite = 0;
	reg [7:0] paddr = 8'h00;
	reg [31:0] pwdata = 32'h0;
	reg cs_n = 0;
	reg sclk = 0;
	reg sdi = 0;
	reg [19:0] drv = 20'h0;
	reg mux_on = 0;
	reg [3:0] gk = 4'h0;
	wire phase, phase_oe;
	wire [31:0] prdata;
	wire pready, pslverr, irq_n;
	wire [19:0] line_in, line_out, line_oe;
	integer fails = 0;
	integer check_count = 0;
	integer seed = 32'h9712;
	integer i;
	reg [4:0] o;
	reg [32:0] e;
	reg [32:0] q[$];

	always #12.5 pclk = ~pclk;

	// short tick keeps millisecond filters quick
	lcio_top #(.VARIANT(0), .TICK_CYCLES(20)) lcio_top_inst (
		.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .line_in(line_in),
		.line_out(line_out), .line_oe(line_oe), .cs_n(cs_n),
		.serial_shift_clock(sclk), .serial_data_line_in(sdi),
		.serial_data_line_out(), .serial_data_line_oe(),
		.regulator_chop_clock(), .demux_phase_out(phase), .demux_phase_oe(phase_oe),
		.irq_n(irq_n));

	lcio_line_model lcio_line_model_inst (.line_out(line_out), .line_oe(line_oe),
		.drv(drv), .mux_on(mux_on), .phase(phase), .gkey(gk), .line_in(line_in));

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task chk(input [32:0] g, input [32:0] x);
		begin
			check_count = check_count + 1;
			if (g !== x) begin
				$display("[ERR] %0t got %h exp %h", $time, g, x);
				fails = fails + 1;
			end
		end
	endtask

	task stop_test;
		begin
			$display("checks %0d fails %0d", check_count, fails);
			if (fails == 0 && check_count > 0)
				$display("Testbench passed");
			else
				$display("Testbench failed");
			$finish;
		end
	endtask

	task cyc(input integer n);
		repeat (n) @(posedge pclk);
	endtask

	// bounded wait for ready so a silent slave ends the run
	task apb(input w, input [7:0] a, input [31:0] d);
		integer n;
		begin
			psel <= 1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge pclk);
			penable <= 1;
			for (n = 0; n < 20 && pready !== 1'b1; n = n + 1)
				@(posedge pclk);
			if (pready !== 1'b1) begin
				fails = fails + 1;
				stop_test;
			end
			psel <= 0;
			penable <= 0;
			@(posedge pclk);
		end
	endtask

	task rd(input [7:0] a, input [32:0] x);
		begin
			q.push_back(x);
			apb(0, a, 0);
		end
	endtask

	task wr(input [7:0] a, input [31:0] d);
		apb(1, a, d);
	endtask

	// read monitor: bit 32 of a note asks for an error answer only
	always @(posedge pclk) begin
		if (psel && penable && pready && !pwrite) begin
			e = q.size() ? q.pop_front() : 33'h1ffffffff;
			if (e[32])
				chk({32'h0, pslverr}, 33'h1);
			else
				chk({pslverr, prdata}, e);
		end
	end

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		cyc(12);
		presetn <= 1;
		cyc(2);
		rd(8'h00, 0);
		rd(8'h04, 0);
		rd(8'h20, 0);
		rd(8'h30, 33'h100000000);
		$display("reset values done");
		o = $random(seed);
		wr(8'h00, 32'h5);
		wr(8'h04, 32'h1f);
		wr(8'h08, {27'h0, o});
		cyc(8);
		chk(line_oe, 20'h07c1f);
		chk(line_out, {5'h0, o, 5'h0, o});
		rd(8'h0c, {o[4:2], 1'b0, o[0]});
		$display("outputs done");
		wr(8'h04, 0);
		wr(8'h00, 32'h2);
		wr(8'h18, 32'h3);
		cyc(300);
		wr(8'h24, 32'hff);
		drv <= 20'h002a0;
		cyc(30);
		rd(8'h0c, 32'h14);
		cyc(120);
		rd(8'h0c, 32'h15);
		chk(irq_n, 1);
		wr(8'h28, 32'h2);
		cyc(3);
		chk(irq_n, 0);
		rd(8'h24, 32'h2);
		cyc(3);
		chk(irq_n, 1);
		rd(8'h10, 32'h2);
		$display("debounce done");
		wr(8'h1c, 0);
		drv <= 20'h002e0;
		cyc(100);
		rd(8'h14, 0);
		cyc(150);
		rd(8'h14, 32'h2);
		rd(8'h24, 32'h20);
		chk(irq_n, 1);
		$display("counter done");
		// multiplexed detector: hook stays high, low ground key replaces line 1
		wr(8'h20, 32'h5);
		mux_on <= 1;
		cyc(250);
		rd(8'h20, 32'h5);
		chk(phase_oe, 1);
		rd(8'h10, 32'h2);
		rd(8'h14, 0);
		$display("demux done");
		// one rise short of a hold reset, then exactly enough
		for (i = 15; i < 17; i = i + 1) begin
			repeat (i) begin
				sclk <= 1;
				cyc(2);
				sclk <= 0;
				cyc(2);
			end
			cs_n <= 1;
			cyc(10);
			cs_n <= 0;
			cyc(4);
			rd(8'h00, i == 15 ? 2 : 0);
		end
		$display("hold reset done");
		stop_test;
	end
endmodule
